// File: common/asu_pkg.sv
// Purpose: Shared constants and types for the asynchronous serial unit.
// Assumes: Byte-wide register port with 16-bit addresses.
// Notes: Frame timing counts ticks of the baud prescaler.
package asu_pkg;
	localparam logic [15:0] ADDR_MODE = 16'hFF70;
	localparam logic [15:0] ADDR_STATUS = 16'hFF71;
	localparam logic [15:0] ADDR_BAUD = 16'hFF72;
	localparam logic [15:0] ADDR_DATA = 16'hFF74;
	localparam int MODE_TX_EN = 7;
	localparam int MODE_RX_EN = 6;
	localparam int MODE_PAR_HI = 5;
	localparam int MODE_PAR_LO = 4;
	localparam int MODE_CHAR = 3;
	localparam int MODE_STOP = 2;
	localparam int MODE_ERR_SUP = 1;
	localparam int STAT_PE = 2;
	localparam int STAT_FE = 1;
	localparam int STAT_OVE = 0;
	localparam int BAUD_SRC_HI = 6;
	localparam int BAUD_SRC_LO = 4;
	localparam int BAUD_DIV_HI = 3;
	localparam int BAUD_DIV_LO = 0;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] RXBUF_RESET = 8'hFF;
	localparam logic [4:0] BIT_BASE = 5'h10;
	localparam logic [3:0] PRESC_EXP_BASE = 4'h1;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;
	localparam logic [2:0] LAST_BIT7 = 3'h6;
	localparam logic [2:0] LAST_BIT8 = 3'h7;

	// Parity bit for a character under the selected mode.
	function automatic logic asu_parity(input logic [7:0] d,
			input logic len8, input logic [1:0] mode);
		logic p;
		p = ^{d[7] & len8, d[6:0]};
		case (mode)
			PAR_ODD: asu_parity = ~p;
			PAR_EVEN: asu_parity = p;
			default: asu_parity = 1'b0;
		endcase
	endfunction
endpackage

// File: hdl/asu_fifo.sv
// Purpose: Transmit FIFO between the register port and the transmitter.
// Assumes: Read data appear one cycle after a pop.
// Notes: Depth must be a power of two.
`timescale 1ns/1ns
module asu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input logic clk_in,
	input logic rst_in,
	input logic in_valid_in,
	output logic in_ready_out,
	input logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready_out = count != (AW+1)'(DEPTH);
	assign out_valid_out = count != '0;
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			out_data_out <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
				out_data_out <= mem[rd_ptr];
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// File: hdl/asu_baud.sv
// Purpose: Baud prescaler giving one tick per half source period.
// Assumes: Selection changes only while no frame is in flight.
// Notes: Tick period is 2 to the power of (select plus one) clocks.
`timescale 1ns/1ns
module asu_baud #(
	parameter int PRESC_W = 8
) (
	input logic clk_in,
	input logic rst_in,
	input logic [2:0] src_sel_in,
	output logic tick_out
);
	logic [PRESC_W-1:0] cnt;
	logic [PRESC_W:0] mask;

	// Twice the source rate, so a bit of 16 plus k ticks lasts half of 16 plus k source periods.
	always_comb begin
		mask = ((PRESC_W+1)'(1) << ({1'b0, src_sel_in} + 4'h1)) - 1'b1; // RULE_16
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt <= '0;
			tick_out <= 1'b0;
		end else begin
			cnt <= cnt + 1'b1;
			tick_out <= (cnt & mask[PRESC_W-1:0]) == mask[PRESC_W-1:0]; // RULE_16
		end
	end
endmodule

// File: hdl/asu_core.sv
// Purpose: Full-duplex asynchronous serial unit with baud generator.
// Assumes: Register strobes and the receive pin are synchronous.
// Notes: Transmit data pass through a FIFO before the shifter.
// Operation
// RULE_01: Transmit and receive enable bits pick off, receive, transmit or both.
// RULE_02: With both enables clear, no transfer and both pins stay plain ports.
// RULE_03: A frame is a start bit then a character; both directions run at once.
// RULE_04: Parity field: none, forced zero unchecked, odd, even.
// RULE_05: Character length bit picks seven or eight data bits.
// RULE_06: Stop length bit picks one or two transmitted stop bits.
// RULE_07: Receiver checks only the first stop bit.
// RULE_08: Suppress bit set blocks the receive-done request for an errored frame.
// RULE_09: Parity error flags a received parity bit that mismatches.
// RULE_10: Framing error flags a missing stop bit.
// RULE_11: Overrun flags a frame completed before the buffer was read.
// RULE_12: Overrun keeps being reported until the receive buffer is read.
// RULE_13: Error status shows the receive error kind and resets to zero.
// RULE_14: Mode register resets to zero, the disabled state.
// RULE_15: Baud register resets to zero and is written as a whole byte.
// RULE_16: Source select gives system clock over two to the (two plus field).
// RULE_17: Divider field divides the source by sixteen plus the field; the code makes a bit 16 plus the field ticks at twice the source rate.
// RULE_18: Software leaves the baud register alone during a transfer.
// RULE_19: Software stops both directions before changing the mode.
// RULE_20: Software writes zero to reserved mode and baud bits.
// RULE_21: Software writes zero to the upper status bits.
// RULE_22: Software sets port latches and directions before serial use.
// RULE_23: A write to the transmit register starts a frame.
// RULE_24: Receive buffer shares the transmit address, resets to ones, top bit zero; the code resets it to FF.
// RULE_25: Idle high, low start, LSB first, optional parity, high stops.
`timescale 1ns/1ns
module asu_core
	import asu_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input logic CLK_SYS_IN,
	input logic RST_IN,
	input logic [15:0] ADDR_IN,
	input logic WR_IN,
	input logic RD_IN,
	input logic [7:0] WDATA_IN,
	output logic [7:0] RDATA_OUT,
	output logic TX_READY_OUT,
	output logic TX_BUSY_OUT,
	output logic RX_DONE_OUT,
	input logic RXD_IN,
	output logic RXD_SERIAL_OUT,
	output logic TXD_OUT,
	output logic TXD_OE_OUT
);
	typedef enum logic [5:0] {
		TX_IDLE = 6'h01,
		TX_LOAD = 6'h02,
		TX_START = 6'h04,
		TX_DATA = 6'h08,
		TX_PAR = 6'h10,
		TX_STOP = 6'h20
	} asu_tx_e;

	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_START = 5'h02,
		RX_DATA = 5'h04,
		RX_PAR = 5'h08,
		RX_STOP = 5'h10
	} asu_rx_e;

	logic [7:0] serial_mode_control;
	logic [7:0] baud_generator_control;
	logic [7:0] receive_error_status;
	logic [7:0] receive_buffer_register;
	logic rx_full;

	logic transmit_enable_bit;
	logic receive_enable_bit;
	logic [1:0] parity_mode;
	logic char_length_bit;
	logic stop_length_bit;
	logic error_irq_suppress_bit;
	logic [4:0] bit_len;
	logic [4:0] half_len;
	logic tick;

	logic wr_mode;
	logic wr_baud;
	logic wr_data;
	logic rd_data;

	logic fifo_valid;
	logic fifo_pop;
	logic [7:0] fifo_data;

	asu_tx_e tx_state;
	logic [4:0] tx_cnt;
	logic [2:0] tx_bitn;
	logic tx_stopn;
	logic [7:0] tx_sh;
	logic tx_par;
	logic tx_bit_end;

	asu_rx_e rx_state;
	logic [4:0] rx_cnt;
	logic [2:0] rx_bitn;
	logic [7:0] rx_sh;
	logic rx_pbit;
	logic rx_sample;
	logic rx_done;
	logic next_pe;
	logic next_fe;
	logic next_ove;

	assign transmit_enable_bit = serial_mode_control[MODE_TX_EN];
	assign receive_enable_bit = serial_mode_control[MODE_RX_EN];
	assign parity_mode = serial_mode_control[MODE_PAR_HI:MODE_PAR_LO];
	assign char_length_bit = serial_mode_control[MODE_CHAR];
	assign stop_length_bit = serial_mode_control[MODE_STOP];
	assign error_irq_suppress_bit = serial_mode_control[MODE_ERR_SUP];

	// A setting of 1111 is not trapped; it simply yields a 31-tick bit.
	assign bit_len = BIT_BASE +
		5'(baud_generator_control[BAUD_DIV_HI:BAUD_DIV_LO]); // RULE_17
	assign half_len = {1'b0, bit_len[4:1]};

	assign wr_mode = WR_IN && ADDR_IN == ADDR_MODE;
	assign wr_baud = WR_IN && ADDR_IN == ADDR_BAUD;
	assign wr_data = WR_IN && ADDR_IN == ADDR_DATA;
	assign rd_data = RD_IN && ADDR_IN == ADDR_DATA; // RULE_24

	asu_baud #(
		.PRESC_W(8)
	) u_baud (
		.clk_in(CLK_SYS_IN),
		.rst_in(RST_IN),
		.src_sel_in(baud_generator_control[BAUD_SRC_HI:BAUD_SRC_LO]),
		.tick_out(tick)
	);

	// Queued bytes let software burst writes without tracking each frame.
	asu_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(CLK_SYS_IN),
		.rst_in(RST_IN),
		.in_valid_in(wr_data),
		.in_ready_out(TX_READY_OUT),
		.in_data_in(WDATA_IN),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_data)
	);

	// Reserved bits are stored as zero whatever software writes.
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			serial_mode_control <= MODE_RESET; // RULE_14
			baud_generator_control <= BAUD_RESET; // RULE_15
		end else begin
			if (wr_mode) begin
				serial_mode_control <= {WDATA_IN[7:1], 1'b0};
			end
			if (wr_baud) begin
				baud_generator_control <= {1'b0, WDATA_IN[6:0]}; // RULE_15
			end
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			RDATA_OUT <= 8'h00;
		end else if (RD_IN) begin
			case (ADDR_IN)
				ADDR_MODE: RDATA_OUT <= serial_mode_control;
				ADDR_STATUS: RDATA_OUT <= receive_error_status;
				ADDR_BAUD: RDATA_OUT <= baud_generator_control;
				ADDR_DATA: RDATA_OUT <= receive_buffer_register; // RULE_24
				default: RDATA_OUT <= 8'h00;
			endcase
		end
	end

	assign fifo_pop = transmit_enable_bit && tx_state == TX_IDLE &&
		fifo_valid; // RULE_23
	assign tx_bit_end = tick && tx_cnt == bit_len - 5'h01;
	assign TX_BUSY_OUT = tx_state != TX_IDLE || fifo_valid;

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN || !transmit_enable_bit) begin // RULE_02
			tx_state <= TX_IDLE;
			tx_cnt <= 5'h00;
			tx_bitn <= 3'h0;
			tx_stopn <= 1'b0;
			tx_sh <= 8'h00;
			tx_par <= 1'b0;
		end else begin
			if (tx_state != TX_IDLE && tx_state != TX_LOAD && tick) begin
				tx_cnt <= tx_bit_end ? 5'h00 : tx_cnt + 5'h01;
			end
			case (tx_state)
				TX_IDLE: begin
					if (fifo_pop) begin
						tx_state <= TX_LOAD; // RULE_23
					end
				end
				TX_LOAD: begin
					tx_sh <= fifo_data;
					tx_par <= asu_parity(fifo_data, char_length_bit,
						parity_mode); // RULE_04
					tx_cnt <= 5'h00;
					tx_bitn <= 3'h0;
					tx_stopn <= 1'b0;
					tx_state <= TX_START;
				end
				TX_START: begin
					if (tx_bit_end) begin
						tx_state <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (tx_bit_end) begin
						tx_sh <= {1'b0, tx_sh[7:1]}; // RULE_25
						tx_bitn <= tx_bitn + 3'h1;
						if (tx_bitn == (char_length_bit ? LAST_BIT8 :
							LAST_BIT7)) begin // RULE_05
							tx_state <= parity_mode == PAR_NONE ?
								TX_STOP : TX_PAR; // RULE_04
						end
					end
				end
				TX_PAR: begin
					if (tx_bit_end) begin
						tx_state <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (tx_bit_end) begin
						if (stop_length_bit && !tx_stopn) begin
							tx_stopn <= 1'b1; // RULE_06
						end else begin
							tx_state <= TX_IDLE;
						end
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// The line lags the state by one clock, far below one bit time.
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			TXD_OUT <= 1'b1;
			TXD_OE_OUT <= 1'b0;
		end else begin
			TXD_OE_OUT <= transmit_enable_bit; // RULE_01
			case (tx_state)
				TX_START: TXD_OUT <= 1'b0; // RULE_25
				TX_DATA: TXD_OUT <= tx_sh[0];
				TX_PAR: TXD_OUT <= tx_par; // RULE_04
				default: TXD_OUT <= 1'b1;
			endcase
		end
	end

	assign RXD_SERIAL_OUT = receive_enable_bit; // RULE_01
	assign rx_sample = tick && (rx_state == RX_START ?
		rx_cnt == half_len - 5'h01 : rx_cnt == bit_len - 5'h01);

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN || !receive_enable_bit) begin // RULE_02
			rx_state <= RX_IDLE;
			rx_cnt <= 5'h00;
			rx_bitn <= 3'h0;
			rx_sh <= 8'h00;
			rx_pbit <= 1'b0;
		end else begin
			if (rx_state != RX_IDLE && tick) begin
				rx_cnt <= rx_sample ? 5'h00 : rx_cnt + 5'h01;
			end
			case (rx_state)
				RX_IDLE: begin
					if (!RXD_IN) begin // RULE_03
						rx_state <= RX_START; // RULE_25
						rx_cnt <= 5'h00;
						rx_bitn <= 3'h0;
						rx_sh <= 8'h00;
					end
				end
				RX_START: begin
					if (rx_sample) begin
						// A glitch shorter than half a bit is discarded.
						rx_state <= RXD_IN ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_sample) begin
						rx_sh[rx_bitn] <= RXD_IN; // RULE_25
						rx_bitn <= rx_bitn + 3'h1;
						if (rx_bitn == (char_length_bit ? LAST_BIT8 :
							LAST_BIT7)) begin // RULE_05
							rx_state <= parity_mode == PAR_NONE ?
								RX_STOP : RX_PAR;
						end
					end
				end
				RX_PAR: begin
					if (rx_sample) begin
						rx_pbit <= RXD_IN;
						rx_state <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_sample) begin
						rx_state <= RX_IDLE; // RULE_07
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	assign rx_done = rx_state == RX_STOP && rx_sample; // RULE_07
	assign next_fe = !RXD_IN; // RULE_10
	assign next_pe = parity_mode[1] && rx_pbit !=
		asu_parity(rx_sh, char_length_bit, parity_mode); // RULE_09
	// A read in the same clock as completion counts as in time.
	assign next_ove = rx_full && !rd_data; // RULE_11

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			receive_error_status <= STATUS_RESET; // RULE_13
		end else if (rx_done) begin
			receive_error_status <= 8'h00;
			receive_error_status[STAT_PE] <= next_pe; // RULE_09
			receive_error_status[STAT_FE] <= next_fe; // RULE_10
			receive_error_status[STAT_OVE] <= next_ove; // RULE_12
		end
	end

	// On overrun the unread byte is kept and the new one is lost.
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			receive_buffer_register <= RXBUF_RESET; // RULE_24
			rx_full <= 1'b0;
		end else begin
			if (rx_done) begin
				rx_full <= 1'b1; // RULE_11
				if (!next_ove) begin
					receive_buffer_register <= rx_sh; // RULE_24
				end
			end else if (rd_data) begin
				rx_full <= 1'b0; // RULE_12
			end
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			RX_DONE_OUT <= 1'b0;
		end else begin
			RX_DONE_OUT <= rx_done && !(error_irq_suppress_bit &&
				(next_pe || next_fe || next_ove)); // RULE_08
		end
	end
endmodule

// File: testbench/asu_chk.sv
// Purpose: Port checker for the asynchronous serial unit.
// Assumes: One clock domain with synchronous reset.
// Notes: Bound to the core module asu_core at the foot of this file.
`timescale 1ns/1ns
module asu_chk
	import asu_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	input wire logic [15:0] ADDR_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic [7:0] RDATA_OUT,
	input wire logic TX_READY_OUT,
	input wire logic TX_BUSY_OUT,
	input wire logic RX_DONE_OUT,
	input wire logic RXD_IN,
	input wire logic RXD_SERIAL_OUT,
	input wire logic TXD_OUT,
	input wire logic TXD_OE_OUT
);
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (RST_IN);
	sequence s_mode_wr;
		WR_IN && ADDR_IN == ADDR_MODE;
	endsequence
	sequence s_mode_rd;
		RD_IN && ADDR_IN == ADDR_MODE;
	endsequence
	property p_oe;
		logic e;
		(s_mode_wr, e = WDATA_IN[MODE_TX_EN]) |-> ##2 TXD_OE_OUT == e;
	endproperty
	property p_sel;
		logic e;
		(s_mode_wr, e = WDATA_IN[MODE_RX_EN]) |=> RXD_SERIAL_OUT == e;
	endproperty
	// Bit 0 is stored as zero whatever was written.
	property p_back;
		logic [7:0] v;
		(s_mode_wr, v = WDATA_IN) ##2 s_mode_rd |=> RDATA_OUT == (v & 8'hFE);
	endproperty
	a_oe_follow: assert property (p_oe)
		else $error("tx pin use wrong");
	a_sel_follow: assert property (p_sel)
		else $error("rx pin use wrong");
	a_mode_read: assert property (p_back)
		else $error("mode readback wrong");
	a_rd_hold: assert property (!$past(RD_IN) |-> $stable(RDATA_OUT))
		else $error("read data moved");
	a_idle_high: assert property (!TXD_OE_OUT |-> TXD_OUT)
		else $error("tx line not idle");
	a_start_low: assert property ($fell(TXD_OUT) |-> !TXD_OUT [*8])
		else $error("start bit short");
	a_done_pulse: assert property (RX_DONE_OUT |=> !RX_DONE_OUT)
		else $error("done not a pulse");
	a_full_busy: assert property (!TX_READY_OUT |-> TX_BUSY_OUT)
		else $error("full but not busy");
endmodule
bind asu_core asu_chk u_chk(.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN),
	.ADDR_IN(ADDR_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .WDATA_IN(WDATA_IN),
	.RDATA_OUT(RDATA_OUT), .TX_READY_OUT(TX_READY_OUT),
	.TX_BUSY_OUT(TX_BUSY_OUT), .RX_DONE_OUT(RX_DONE_OUT), .RXD_IN(RXD_IN),
	.RXD_SERIAL_OUT(RXD_SERIAL_OUT), .TXD_OUT(TXD_OUT),
	.TXD_OE_OUT(TXD_OE_OUT));

// File: testbench/asu_peer.sv
// Purpose: Remote serial peer on the receive and transmit lines.
// Assumes: Fixed bit time of BIT clocks.
// Notes: Frames are handed over as bit vectors, first slot in bit 0.
`timescale 1ns/1ns
module asu_peer #(
	parameter int BIT = 32
) (
	input wire logic clk_in,
	input wire logic txd_in,
	output logic rxd_out
);
	// The line idles high between frames, as a pulled-up wire would.
	initial rxd_out = 1'b1;
	task automatic send(input logic [12:0] f, input int n);
		int i;
		@(negedge clk_in);
		for (i = 0; i < n; i++) begin
			rxd_out = f[i];
			repeat (BIT) @(negedge clk_in);
		end
		rxd_out = 1'b1;
	endtask
	// Capture may start a few clocks late; mid-bit sampling leaves margin.
	task automatic grab(output logic [12:0] v);
		int i;
		for (i = 0; i < 4000 && txd_in !== 1'b0; i++)
			@(negedge clk_in);
		repeat (BIT / 2) @(negedge clk_in);
		for (i = 0; i < 13; i++) begin
			v[i] = txd_in;
			repeat (BIT) @(negedge clk_in);
		end
	endtask
endmodule

// File: testbench/async_serial_uart_core_tb_top.sv
// Purpose: Self-checking bench for the asynchronous serial unit.
// Assumes: Baud value 00 gives 32-clock bits, matching the peer.
// Notes: Inputs change on the falling clock edge.
`timescale 1ns/1ns
module async_serial_uart_core_tb_top
	import asu_pkg::*;
;
	localparam int DEPTH = 16;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wd = 8'h00;
	logic [7:0] rdata;
	logic rdy, busy, done, rxd, rxsel, txd, oe;
	logic txq = 1'b1;
	logic [12:0] v;
	int failures = 0;
	int cmp_count = 0;
	int nfall = 0;
	int ndone = 0;
	always #50 clk = ~clk;
	asu_core #(.FIFO_DEPTH(DEPTH)) u_dut(.CLK_SYS_IN(clk), .RST_IN(rst),
		.ADDR_IN(addr), .WR_IN(wr), .RD_IN(rd), .WDATA_IN(wd),
		.RDATA_OUT(rdata), .TX_READY_OUT(rdy), .TX_BUSY_OUT(busy),
		.RX_DONE_OUT(done), .RXD_IN(rxd), .RXD_SERIAL_OUT(rxsel),
		.TXD_OUT(txd), .TXD_OE_OUT(oe));
	asu_peer u_peer(.clk_in(clk), .txd_in(txd), .rxd_out(rxd));
	always @(negedge clk) begin
		txq <= txd;
		if (txq === 1'b1 && txd === 1'b0)
			nfall++;
		if (done === 1'b1)
			ndone++;
	end
	task automatic print_verdict();
		if (failures == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [12:0] g, input logic [12:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// An exhausted wait ends the run at once rather than cascading.
	task automatic time_out();
		failures++;
		$display("Error at %0t: wait timed out", $time);
		print_verdict();
	endtask
	task automatic wait_sig(ref logic s, input logic b);
		int i;
		for (i = 0; i < 9000 && s !== b; i++)
			@(negedge clk);
		if (s !== b)
			time_out();
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
	endtask
	// Both directions are stopped before any new mode goes in.
	task automatic set_mode(input logic [7:0] m);
		wr_reg(ADDR_MODE, 8'h00);
		wr_reg(ADDR_MODE, m);
	endtask
	function automatic logic [12:0] frm(input logic [7:0] d, input int n = 8,
			input logic [1:0] pm = 2'h0, input logic s = 1'b1);
		logic [12:0] f;
		logic p;
		int k;
		f = 13'h1FFF;
		p = ^(d & (n == 8 ? 8'hFF : 8'h7F));
		f[0] = 1'b0;
		for (k = 0; k < n; k++)
			f[k + 1] = d[k];
		k = n + 1;
		if (pm != 2'h0) begin
			f[k] = pm == 2'h1 ? 1'b0 : (pm == 2'h2 ? ~p : p);
			k++;
		end
		f[k + 1] = s;
		return f;
	endfunction
	task automatic t_regs();
		logic [7:0] d;
		rd_reg(ADDR_MODE, d);
		chk(d, 8'h00);
		rd_reg(ADDR_STATUS, d);
		chk(d, 8'h00);
		rd_reg(ADDR_BAUD, d);
		chk(d, 8'h00);
		rd_reg(ADDR_DATA, d);
		chk(d, 8'hFF);
		chk({txd, oe, rxsel}, 3'h4);
		wr_reg(ADDR_BAUD, 8'h3B);
		rd_reg(ADDR_BAUD, d);
		chk(d, 8'h3B);
		wr_reg(ADDR_STATUS, 8'h07);
		rd_reg(ADDR_STATUS, d);
		chk(d, 8'h00);
		wr_reg(ADDR_MODE, 8'h3E);
		rd_reg(ADDR_MODE, d);
		chk(d, 8'h3E);
		rd_reg(16'hFF73, d);
		chk(d, 8'h00);
	endtask
	task automatic t_baud();
		logic [7:0] c [3] = '{8'h00, 8'h1E, 8'h21};
		int n;
		foreach (c[j]) begin
			wait_sig(busy, 1'b0);
			wr_reg(ADDR_BAUD, c[j]);
			set_mode(8'h88);
			wr_reg(ADDR_DATA, 8'h01);
			wait_sig(txd, 1'b0);
			wait_sig(txd, 1'b1);
			for (n = 0; n < 9000 && txd !== 1'b0; n++)
				@(negedge clk);
			if (n == 9000)
				time_out();
			n = n >> (int'(c[j][6:4]) + 1);
			chk(13'(n), 13'(16 + int'(c[j][3:0])));
		end
		wait_sig(busy, 1'b0);
		wr_reg(ADDR_BAUD, 8'h00);
	endtask
	// Two bytes go back to back so the slot after the stop shows its count.
	task automatic t_tx();
		logic [7:0] m [4] = '{8'h80, 8'h9C, 8'hA8, 8'hB4};
		logic [12:0] k;
		int n;
		foreach (m[j]) begin
			n = m[j][MODE_CHAR] ? 8 : 7;
			k = (13'h1 << (n + 3 + int'(m[j][5:4] != 2'h0))) - 13'h1;
			wait_sig(busy, 1'b0);
			set_mode(m[j]);
			wr_reg(ADDR_DATA, 8'hA5);
			wr_reg(ADDR_DATA, 8'hA5);
			wait_sig(txd, 1'b0);
			u_peer.grab(v);
			chk(v & k, frm(8'hA5, n, m[j][5:4], m[j][2]) & k);
		end
	endtask
	task automatic t_fifo();
		wait_sig(busy, 1'b0);
		set_mode(8'h88);
		nfall = 0;
		repeat (DEPTH + 4) wr_reg(ADDR_DATA, 8'hFF);
		chk(rdy, 1'b0);
		wait_sig(busy, 1'b0);
		chk(13'(nfall), 13'(DEPTH + 1));
		chk(rdy, 1'b1);
	endtask
	task automatic t_duplex();
		logic [7:0] d;
		set_mode(8'hC8);
		ndone = 0;
		wr_reg(ADDR_DATA, 8'hA5);
		fork
			begin
				wait_sig(txd, 1'b0);
				u_peer.grab(v);
			end
			u_peer.send(frm(8'h3C), 12);
		join
		chk(v & 13'h3FF, frm(8'hA5) & 13'h3FF);
		rd_reg(ADDR_DATA, d);
		chk(d, 8'h3C);
		chk(13'(ndone), 13'h1);
	endtask
	task automatic rx_case(input logic [7:0] m, input logic [12:0] f,
			input logic [7:0] st, input logic [12:0] dn);
		logic [7:0] d;
		if (m != 8'h00)
			set_mode(m);
		ndone = 0;
		u_peer.send(f, 12);
		rd_reg(ADDR_STATUS, d);
		chk(d, st);
		chk(13'(ndone), dn);
	endtask
	task automatic t_rx();
		logic [7:0] d;
		logic [12:0] f;
		rx_case(8'h40, frm(8'h7F, 7), 8'h00, 13'h1);
		rd_reg(ADDR_DATA, d);
		chk(d, 8'h7F);
		rx_case(8'h68, frm(8'h3C, 8, 2'h3), 8'h04, 13'h1);
		rd_reg(ADDR_DATA, d);
		rx_case(8'h58, frm(8'h3C, 8, 2'h2), 8'h00, 13'h1);
		rd_reg(ADDR_DATA, d);
		f = frm(8'h3C, 8, 2'h2) & 13'h1BFF;
		rx_case(8'h6A, f, 8'h02, 13'h0);
		rd_reg(ADDR_DATA, d);
		set_mode(8'h4C);
		u_peer.send(frm(8'hA1), 10);
		rx_case(8'h00, frm(8'hB2), 8'h01, 13'h1);
		rx_case(8'h00, frm(8'hC3), 8'h01, 13'h1);
		rd_reg(ADDR_DATA, d);
		chk(d, 8'hA1);
		rx_case(8'h00, frm(8'hD4), 8'h00, 13'h1);
		rd_reg(ADDR_DATA, d);
		chk(d, 8'hD4);
		rx_case(8'h80, frm(8'h55), 8'h00, 13'h0);
		rd_reg(ADDR_DATA, d);
		chk(d, 8'hD4);
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_regs();
		t_baud();
		t_tx();
		t_fifo();
		t_duplex();
		t_rx();
		print_verdict();
	end
endmodule
